// file: core/link_control_pkg.sv
package link_control_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [11:0] LINK_CTRL_SET_OFF = 12'h0e0;
   localparam logic [11:0] LINK_CTRL_CLR_OFF = 12'h0e4;
   localparam logic [11:0] NODE_IDENT_OFF = 12'h0e8;
   localparam logic [11:0] INT_STATUS_OFF = 12'h100;
   localparam logic [11:0] INT_MASK_OFF = 12'h104;
   localparam logic [11:0] SYNC_FILTER_OFF = 12'h108;
   localparam logic [11:0] CYCLE_OFFSET_OFF = 12'h10c;

   // ----------------------------------------------------------------
   // Link control fields
   // ----------------------------------------------------------------
   localparam int ROLL_SEL_BIT = 22;
   localparam int GEN_EN_BIT = 21;
   localparam int COUNT_EN_BIT = 20;
   localparam int PHY_PKT_BIT = 10;
   localparam int SELF_ID_BIT = 9;
   localparam int LOCK_BIT = 6;
   localparam logic [31:0] LINK_CTRL_USED = 32'h0070_0640;

   typedef struct packed {
      logic cycle_rollover_select;
      logic cycle_start_generator_enable;
      logic cycle_offset_count_enable;
      logic phy_packet_receive_enable;
      logic self_id_receive_enable;
      logic sync_filter_force_lock;
   } link_ctrl_t;

   localparam link_ctrl_t LINK_CTRL_RESET = '0;

   // ----------------------------------------------------------------
   // Node identity fields
   // ----------------------------------------------------------------
   localparam int ID_VALID_BIT = 31;
   localparam int ROOT_BIT = 30;
   localparam int CABLE_OK_BIT = 27;
   localparam int BUS_LSB = 6;
   localparam int BUS_W = 10;
   localparam int NODE_W = 6;
   localparam logic [BUS_W-1:0] BUS_NUMBER_RESET = 10'h3ff;

   typedef struct packed {
      logic id_valid;
      logic root;
      logic cable_ok;
      logic [BUS_W-1:0] bus_segment_number;
      logic [NODE_W-1:0] physical_node_number;
   } node_ident_t;

   // ----------------------------------------------------------------
   // Interrupt events
   // ----------------------------------------------------------------
   localparam int EV_W = 2;
   localparam int EV_ROLLOVER = 0;
   localparam int EV_OVERLONG = 1;
   localparam logic [EV_W-1:0] EV_RESET = 2'h0;

   // ----------------------------------------------------------------
   // Cycle timer
   // ----------------------------------------------------------------
   localparam int OFFSET_W = 12;
   localparam logic [OFFSET_W:0] CYCLE_TICKS = 13'h0c00;
   localparam int unsigned CLK_HZ = 10000000;
   localparam int unsigned TICK_HZ = 24576000;
   localparam logic [OFFSET_W-1:0] OFFSET_RESET = 12'h000;
   localparam logic [31:0] ACC_RESET = 32'h0000_0000;

endpackage

// file: core/cycle_offset_counter.sv
`timescale 1ns/1ps
module cycle_offset_counter
   import link_control_pkg::*;
#(
   parameter int unsigned CLK_HZ_P = CLK_HZ,
   parameter int unsigned TICK_HZ_P = TICK_HZ
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic count_en,
   input wire logic external_mode,
   input wire logic external_edge,
   input wire logic load,
   input wire logic [OFFSET_W-1:0] load_value,
   output logic [OFFSET_W-1:0] cycle_offset,
   output logic rollover
);

   logic [31:0] acc;
   logic [31:0] next_acc;
   logic [31:0] sum;
   logic [1:0] ticks;
   logic [OFFSET_W:0] stepped;
   logic [OFFSET_W-1:0] next_offset;
   logic next_rollover;

   // Whole ticks of the fast clock within one pclk period
   function automatic logic [1:0] ticks_of(input logic [31:0] s);
      if (s >= 3 * CLK_HZ_P) begin
         return 2'd3;
      end else if (s >= 2 * CLK_HZ_P) begin
         return 2'd2;
      end else if (s >= CLK_HZ_P) begin
         return 2'd1;
      end
      return 2'd0;
   endfunction

   // ----------------------------------------------------------------
   // Offset and rollover
   // ----------------------------------------------------------------
   always_comb begin
      sum = acc + TICK_HZ_P;
      ticks = ticks_of(sum);
      next_acc = sum - 32'(ticks * CLK_HZ_P);
      stepped = {1'b0, cycle_offset} + {11'h000, ticks};
      next_offset = cycle_offset;
      next_rollover = 1'b0;
      if (load) begin
         next_offset = load_value;
      end else if (count_en) begin
         if (external_mode) begin
            if (external_edge) begin
               next_offset = OFFSET_RESET;
               next_rollover = 1'b1;
            end else if (stepped >= CYCLE_TICKS) begin
               next_offset = OFFSET_W'(stepped - CYCLE_TICKS);
            end else begin
               next_offset = stepped[OFFSET_W-1:0];
            end
         end else if (stepped >= CYCLE_TICKS) begin
            next_offset = OFFSET_W'(stepped - CYCLE_TICKS);
            next_rollover = 1'b1;
         end else begin
            next_offset = stepped[OFFSET_W-1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc <= ACC_RESET;
         cycle_offset <= OFFSET_RESET;
         rollover <= 1'b0;
      end else begin
         acc <= next_acc;
         cycle_offset <= next_offset;
         rollover <= next_rollover;
      end
   end

   property p_internal_wrap;
      @(posedge pclk) disable iff (!presetn)
      !load && count_en && !external_mode && stepped >= CYCLE_TICKS
      |=> rollover && cycle_offset < 12'h003;
   endproperty
   a_internal_wrap: assert property (p_internal_wrap) else $error("internal wrap missed");

endmodule // cycle_offset_counter

// file: core/link_control_cycle_timer.sv
`timescale 1ns/1ps
module link_control_cycle_timer
   import link_control_pkg::*;
#(
   parameter int NUM_CONTEXTS = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic external_cycle_input,
   input wire logic phy_node_valid,
   input wire logic [NODE_W-1:0] phy_node_number,
   input wire logic phy_root,
   input wire logic phy_cable_ok,
   input wire logic bus_reset,
   input wire logic overlong_cycle_event,
   input wire logic cycle_start_rx_valid,
   input wire logic [OFFSET_W-1:0] cycle_start_rx_offset,
   output logic cycle_start_emit,
   output logic [OFFSET_W-1:0] cycle_offset,
   input wire logic async_receive_request_enable,
   input wire logic phy_packet_rx,
   output logic phy_packet_accept,
   input wire logic self_id_rx,
   output logic self_id_accept,
   output logic [15:0] node_id,
   output logic [NUM_CONTEXTS-1:0] sync_filter_bit,
   output logic irq
);

   link_ctrl_t ctrl;
   link_ctrl_t next_ctrl;
   node_ident_t ident;
   node_ident_t next_ident;
   logic [EV_W-1:0] status;
   logic [EV_W-1:0] next_status;
   logic [EV_W-1:0] mask;
   logic [EV_W-1:0] next_mask;
   logic [NUM_CONTEXTS-1:0] sync_store;
   logic [NUM_CONTEXTS-1:0] next_sync_store;
   logic [31:0] next_prdata;
   logic ext_q1;
   logic ext_q2;
   logic ext_q3;
   logic ext_edge;
   logic rollover;
   logic rx_load;
   logic wr;
   logic hit;

   function automatic logic [31:0] ctrl_word(input link_ctrl_t c);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[ROLL_SEL_BIT] = c.cycle_rollover_select;
      w[GEN_EN_BIT] = c.cycle_start_generator_enable;
      w[COUNT_EN_BIT] = c.cycle_offset_count_enable;
      w[PHY_PKT_BIT] = c.phy_packet_receive_enable;
      w[SELF_ID_BIT] = c.self_id_receive_enable;
      w[LOCK_BIT] = c.sync_filter_force_lock;
      return w;
   endfunction

   // ----------------------------------------------------------------
   // External cycle input synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_q1 <= 1'b0;
         ext_q2 <= 1'b0;
         ext_q3 <= 1'b0;
      end else begin
         ext_q1 <= external_cycle_input;
         ext_q2 <= ext_q1;
         ext_q3 <= ext_q2;
      end
   end

   assign ext_edge = ext_q2 && !ext_q3;
   assign rx_load = cycle_start_rx_valid && !ident.root;

   cycle_offset_counter u_counter (
      .pclk(pclk),
      .presetn(presetn),
      .count_en(ctrl.cycle_offset_count_enable),
      .external_mode(ctrl.cycle_rollover_select),
      .external_edge(ext_edge),
      .load(rx_load),
      .load_value(cycle_start_rx_offset),
      .cycle_offset(cycle_offset),
      .rollover(rollover)
   );

   // ----------------------------------------------------------------
   // Bus decode and outputs
   // ----------------------------------------------------------------
   assign wr = psel && penable && pwrite;
   assign hit = paddr == LINK_CTRL_SET_OFF || paddr == LINK_CTRL_CLR_OFF ||
                paddr == NODE_IDENT_OFF || paddr == INT_STATUS_OFF ||
                paddr == INT_MASK_OFF || paddr == SYNC_FILTER_OFF ||
                paddr == CYCLE_OFFSET_OFF;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;
   assign irq = |(status & mask);
   assign cycle_start_emit = rollover && ctrl.cycle_start_generator_enable && ident.root;
   assign phy_packet_accept = phy_packet_rx && ctrl.phy_packet_receive_enable &&
                              async_receive_request_enable;
   assign self_id_accept = self_id_rx && ctrl.self_id_receive_enable;
   assign node_id = {ident.bus_segment_number, ident.physical_node_number};
   assign sync_filter_bit = sync_store | {NUM_CONTEXTS{ctrl.sync_filter_force_lock}};

   // ----------------------------------------------------------------
   // Register next values
   // ----------------------------------------------------------------
   always_comb begin
      next_ctrl = ctrl;
      next_ident = ident;
      next_mask = mask;
      next_sync_store = sync_store;
      next_status = status;
      next_prdata = prdata;
      if (wr && paddr == LINK_CTRL_SET_OFF) begin
         next_ctrl.cycle_rollover_select = ctrl.cycle_rollover_select | pwdata[ROLL_SEL_BIT];
         next_ctrl.cycle_start_generator_enable = ctrl.cycle_start_generator_enable |
            (pwdata[GEN_EN_BIT] && !status[EV_OVERLONG]);
         next_ctrl.cycle_offset_count_enable = ctrl.cycle_offset_count_enable |
            pwdata[COUNT_EN_BIT];
         next_ctrl.phy_packet_receive_enable = ctrl.phy_packet_receive_enable |
            pwdata[PHY_PKT_BIT];
         next_ctrl.self_id_receive_enable = ctrl.self_id_receive_enable | pwdata[SELF_ID_BIT];
         next_ctrl.sync_filter_force_lock = ctrl.sync_filter_force_lock | pwdata[LOCK_BIT];
      end
      if (wr && paddr == LINK_CTRL_CLR_OFF) begin
         next_ctrl.cycle_rollover_select = ctrl.cycle_rollover_select & !pwdata[ROLL_SEL_BIT];
         next_ctrl.cycle_start_generator_enable = ctrl.cycle_start_generator_enable &
            !pwdata[GEN_EN_BIT];
         next_ctrl.cycle_offset_count_enable = ctrl.cycle_offset_count_enable &
            !pwdata[COUNT_EN_BIT];
         next_ctrl.phy_packet_receive_enable = ctrl.phy_packet_receive_enable &
            !pwdata[PHY_PKT_BIT];
         next_ctrl.self_id_receive_enable = ctrl.self_id_receive_enable & !pwdata[SELF_ID_BIT];
      end
      if (wr && paddr == NODE_IDENT_OFF) begin
         next_ident.bus_segment_number = pwdata[BUS_LSB +: BUS_W];
      end
      if (bus_reset) begin
         next_ident.id_valid = 1'b0;
      end else if (phy_node_valid) begin
         next_ident.id_valid = 1'b1;
         next_ident.root = phy_root;
         next_ident.physical_node_number = phy_node_number;
      end
      next_ident.cable_ok = phy_cable_ok;
      if (wr && paddr == INT_MASK_OFF) begin
         next_mask = pwdata[EV_W-1:0];
      end
      if (wr && paddr == SYNC_FILTER_OFF) begin
         next_sync_store = pwdata[NUM_CONTEXTS-1:0];
      end
      if (wr && paddr == INT_STATUS_OFF) begin
         next_status = status & ~pwdata[EV_W-1:0];
      end
      next_status[EV_ROLLOVER] = next_status[EV_ROLLOVER] | rollover;
      next_status[EV_OVERLONG] = next_status[EV_OVERLONG] | overlong_cycle_event;
      if (next_status[EV_OVERLONG]) begin
         next_ctrl.cycle_start_generator_enable = 1'b0;
      end
      if (psel && !penable) begin
         unique case (paddr)
            LINK_CTRL_SET_OFF, LINK_CTRL_CLR_OFF: next_prdata = ctrl_word(ctrl);
            NODE_IDENT_OFF: begin
               next_prdata = 32'h0000_0000;
               next_prdata[ID_VALID_BIT] = ident.id_valid;
               next_prdata[ROOT_BIT] = ident.root;
               next_prdata[CABLE_OK_BIT] = ident.cable_ok;
               next_prdata[15:0] = node_id;
            end
            INT_STATUS_OFF: next_prdata = {{(32-EV_W){1'b0}}, status};
            INT_MASK_OFF: next_prdata = {{(32-EV_W){1'b0}}, mask};
            SYNC_FILTER_OFF: next_prdata = {{(32-NUM_CONTEXTS){1'b0}}, sync_filter_bit};
            CYCLE_OFFSET_OFF: next_prdata = {{(32-OFFSET_W){1'b0}}, cycle_offset};
            default: next_prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= LINK_CTRL_RESET;
         ident <= '{id_valid: 1'b0, root: 1'b0, cable_ok: 1'b0,
                    bus_segment_number: BUS_NUMBER_RESET, physical_node_number: '0};
         status <= EV_RESET;
         mask <= EV_RESET;
         sync_store <= '0;
         prdata <= 32'h0000_0000;
      end else begin
         ctrl <= next_ctrl;
         ident <= next_ident;
         status <= next_status;
         mask <= next_mask;
         sync_store <= next_sync_store;
         prdata <= next_prdata;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_reserved_zero;
      psel && !penable && (paddr == LINK_CTRL_SET_OFF || paddr == LINK_CTRL_CLR_OFF)
      |=> (prdata & ~LINK_CTRL_USED) == 32'h0000_0000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

   property p_external_roll;
      ctrl.cycle_rollover_select && ctrl.cycle_offset_count_enable && ext_edge && !rx_load
      |=> rollover && cycle_offset == OFFSET_RESET;
   endproperty
   a_external_roll: assert property (p_external_roll) else $error("external roll missed");

   property p_emit;
      ident.root && $past(ident.root) && !$past(ctrl.cycle_rollover_select) &&
      ctrl.cycle_start_generator_enable && cycle_offset < $past(cycle_offset)
      |-> cycle_start_emit;
   endproperty
   a_emit: assert property (p_emit) else $error("cycle start not emitted");

   property p_rx_sync;
      cycle_start_rx_valid && !ident.root |=> cycle_offset == $past(cycle_start_rx_offset);
   endproperty
   a_rx_sync: assert property (p_rx_sync) else $error("received cycle start ignored");

   property p_overlong_clear;
      $rose(status[EV_OVERLONG]) |-> !ctrl.cycle_start_generator_enable;
   endproperty
   a_overlong_clear: assert property (p_overlong_clear) else $error("generator kept on");

   property p_set_blocked;
      status[EV_OVERLONG] && !ctrl.cycle_start_generator_enable
      |=> !ctrl.cycle_start_generator_enable;
   endproperty
   a_set_blocked: assert property (p_set_blocked) else $error("generator set while overlong");

   property p_hold;
      !ctrl.cycle_offset_count_enable && !rx_load |=> $stable(cycle_offset);
   endproperty
   a_hold: assert property (p_hold) else $error("offset moved while disabled");

   property p_phy_accept;
      phy_packet_accept |-> ctrl.phy_packet_receive_enable && async_receive_request_enable;
   endproperty
   a_phy_accept: assert property (p_phy_accept) else $error("phy packet wrongly taken");

   property p_lock_read;
      ctrl.sync_filter_force_lock && psel && !penable && paddr == SYNC_FILTER_OFF
      |=> prdata[NUM_CONTEXTS-1:0] == {NUM_CONTEXTS{1'b1}};
   endproperty
   a_lock_read: assert property (p_lock_read) else $error("sync bit not forced");

   property p_node_id;
      wr && paddr == NODE_IDENT_OFF |=> node_id[15:6] == $past(pwdata[15:6]);
   endproperty
   a_node_id: assert property (p_node_id) else $error("bus number not stored");

   property p_lock_sticky;
      ctrl.sync_filter_force_lock |=> ctrl.sync_filter_force_lock;
   endproperty
   a_lock_sticky: assert property (p_lock_sticky) else $error("lock cleared");

   property p_sync_write;
      wr && paddr == SYNC_FILTER_OFF |=> sync_store == $past(pwdata[NUM_CONTEXTS-1:0]);
   endproperty
   a_sync_write: assert property (p_sync_write) else $error("sync bits not stored");

   property p_clear_addr;
      wr && paddr == LINK_CTRL_CLR_OFF && pwdata[COUNT_EN_BIT]
      |=> !ctrl.cycle_offset_count_enable;
   endproperty
   a_clear_addr: assert property (p_clear_addr) else $error("clear address ignored");

endmodule // link_control_cycle_timer

// file: test/phy_link_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Far-side link model: node numbers, cycle events, packet arrivals
// ----------------------------------------------------------------
module phy_link_model
   import link_control_pkg::*;
(
   input wire logic pclk,
   output logic external_cycle_input,
   output logic phy_node_valid,
   output logic [NODE_W-1:0] phy_node_number,
   output logic phy_root,
   output logic phy_cable_ok,
   output logic bus_reset,
   output logic overlong_cycle_event,
   output logic cycle_start_rx_valid,
   output logic [OFFSET_W-1:0] cycle_start_rx_offset,
   output logic phy_packet_rx,
   output logic self_id_rx
);
   initial begin
      external_cycle_input = 1'b0;
      phy_node_valid = 1'b0;
      phy_node_number = '0;
      phy_root = 1'b0;
      phy_cable_ok = 1'b1;
      bus_reset = 1'b0;
      overlong_cycle_event = 1'b0;
      cycle_start_rx_valid = 1'b0;
      cycle_start_rx_offset = '0;
      phy_packet_rx = 1'b0;
      self_id_rx = 1'b0;
   end

   // Bus reset, then a new node number; fields scrambled once stale
   task automatic send_node(input logic [NODE_W-1:0] num, input logic root);
      @(posedge pclk);
      bus_reset <= 1'b1;
      @(posedge pclk);
      bus_reset <= 1'b0;
      phy_node_valid <= 1'b1;
      phy_node_number <= num;
      phy_root <= root;
      @(posedge pclk);
      phy_node_valid <= 1'b0;
      phy_node_number <= ~num;
      phy_root <= ~root;
   endtask

   task automatic pulse_overlong();
      @(posedge pclk);
      overlong_cycle_event <= 1'b1;
      @(posedge pclk);
      overlong_cycle_event <= 1'b0;
   endtask

   // Held long enough to pass the three-stage synchroniser
   task automatic ext_pulse();
      @(posedge pclk);
      external_cycle_input <= 1'b1;
      repeat (4) @(posedge pclk);
      external_cycle_input <= 1'b0;
   endtask

   task automatic send_cycle_start(input logic [OFFSET_W-1:0] off);
      @(posedge pclk);
      cycle_start_rx_valid <= 1'b1;
      cycle_start_rx_offset <= off;
      @(posedge pclk);
      cycle_start_rx_valid <= 1'b0;
      cycle_start_rx_offset <= ~off;
   endtask

   task automatic set_rx(input logic phy, input logic sid);
      phy_packet_rx <= phy;
      self_id_rx <= sid;
   endtask
endmodule // phy_link_model

// file: test/test_link_control_cycle_timer.sv
`timescale 1ns/1ps
module test_link_control_cycle_timer;
   import link_control_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic ext_in, node_valid, root, cable_ok, bus_reset, overlong, cs_valid, phy_rx, sid_rx;
   logic [NODE_W-1:0] node_num;
   logic [OFFSET_W-1:0] cs_offset;
   logic are = 1'b0;
   logic cycle_start_emit;
   logic [OFFSET_W-1:0] cycle_offset;
   logic phy_packet_accept;
   logic self_id_accept;
   logic [15:0] node_id;
   logic [3:0] sync_filter_bit;
   logic irq;
   logic [31:0] rd;
   logic rd_err;
   int err_count = 0;
   int num_checks = 0;
   int cyc;

   always #50 pclk = ~pclk;

   link_control_cycle_timer #(.NUM_CONTEXTS(4)) link_control_cycle_timer_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .external_cycle_input(ext_in), .phy_node_valid(node_valid), .phy_node_number(node_num),
      .phy_root(root), .phy_cable_ok(cable_ok), .bus_reset(bus_reset),
      .overlong_cycle_event(overlong), .cycle_start_rx_valid(cs_valid),
      .cycle_start_rx_offset(cs_offset), .cycle_start_emit(cycle_start_emit),
      .cycle_offset(cycle_offset), .async_receive_request_enable(are),
      .phy_packet_rx(phy_rx), .phy_packet_accept(phy_packet_accept), .self_id_rx(sid_rx),
      .self_id_accept(self_id_accept), .node_id(node_id), .sync_filter_bit(sync_filter_bit),
      .irq(irq));

   phy_link_model phy_link_model_inst (
      .pclk(pclk), .external_cycle_input(ext_in), .phy_node_valid(node_valid),
      .phy_node_number(node_num), .phy_root(root), .phy_cable_ok(cable_ok),
      .bus_reset(bus_reset), .overlong_cycle_event(overlong), .cycle_start_rx_valid(cs_valid),
      .cycle_start_rx_offset(cs_offset), .phy_packet_rx(phy_rx), .self_id_rx(sid_rx));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [ADDR_W-1:0] addr, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input logic [ADDR_W-1:0] addr, input logic [31:0] exp);
      apb(1'b0, addr, '0);
      check(rd, exp);
   endtask

   task automatic wait_emit(input int lim);
      cyc = 0;
      do begin
         @(posedge pclk);
         cyc++;
      end while (cycle_start_emit !== 1'b1 && cyc < lim);
   endtask

   task automatic summarize();
      if (err_count == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_defaults();
      apb(1'b1, 12'h0f0, 32'hffff_ffff);
      check({31'h0, rd_err}, 32'h1);
      rchk(LINK_CTRL_SET_OFF, 32'h0);
      rchk(NODE_IDENT_OFF, 32'h0800_ffc0);
      rchk(INT_STATUS_OFF, 32'h0);
   endtask

   task automatic t_sync_lock();
      apb(1'b1, SYNC_FILTER_OFF, 32'h5);
      rchk(SYNC_FILTER_OFF, 32'h5);
      check({28'h0, sync_filter_bit}, 32'h5);
      // Self-ID buffer pointer lives outside this block and counts as loaded
      apb(1'b1, LINK_CTRL_SET_OFF, 32'hffff_ffff);
      rchk(LINK_CTRL_CLR_OFF, LINK_CTRL_USED);
      check({28'h0, sync_filter_bit}, 32'hf);
      apb(1'b1, SYNC_FILTER_OFF, 32'h0);
      rchk(SYNC_FILTER_OFF, 32'hf);
      apb(1'b1, LINK_CTRL_CLR_OFF, 32'hffff_ffff);
      rchk(LINK_CTRL_SET_OFF, 32'h40);
   endtask

   task automatic t_node();
      phy_link_model_inst.send_node(6'h2a, 1'b1);
      apb(1'b1, NODE_IDENT_OFF, 32'hffff_5540);
      rchk(NODE_IDENT_OFF, 32'hc800_556a);
      check({16'h0, node_id}, 32'h556a);
   endtask

   task automatic t_internal();
      logic [31:0] held;
      apb(1'b1, LINK_CTRL_SET_OFF, 32'h0020_0000);
      apb(1'b1, INT_MASK_OFF, 32'h1);
      apb(1'b0, CYCLE_OFFSET_OFF, '0);
      held = rd;
      repeat (20) @(posedge pclk);
      rchk(CYCLE_OFFSET_OFF, held);
      apb(1'b1, LINK_CTRL_SET_OFF, 32'h0010_0000);
      wait_emit(1400);
      check({31'h0, cycle_start_emit}, 32'h1);
      wait_emit(1400);
      check(cyc, 32'd1250);
      check({31'h0, cycle_offset < 12'h003}, 32'h1);
      @(posedge pclk);
      check({31'h0, irq}, 32'h1);
      apb(1'b1, LINK_CTRL_CLR_OFF, 32'h0020_0000);
      wait_emit(1300);
      check({31'h0, cycle_start_emit}, 32'h0);
   endtask

   task automatic t_external();
      apb(1'b1, LINK_CTRL_SET_OFF, 32'h0060_0000);
      wait_emit(1300);
      check({31'h0, cycle_start_emit}, 32'h0);
      fork
         phy_link_model_inst.ext_pulse();
         wait_emit(10);
      join
      check({31'h0, cycle_start_emit}, 32'h1);
      check({20'h0, cycle_offset}, 32'h0);
      apb(1'b1, LINK_CTRL_CLR_OFF, 32'h0070_0000);
      apb(1'b1, INT_STATUS_OFF, 32'h3);
   endtask

   task automatic t_overlong();
      apb(1'b1, LINK_CTRL_SET_OFF, 32'h0020_0000);
      rchk(LINK_CTRL_SET_OFF, 32'h0020_0040);
      phy_link_model_inst.pulse_overlong();
      rchk(LINK_CTRL_SET_OFF, 32'h40);
      apb(1'b1, LINK_CTRL_SET_OFF, 32'h0020_0000);
      rchk(LINK_CTRL_SET_OFF, 32'h40);
      rchk(INT_STATUS_OFF, 32'h2);
      apb(1'b1, INT_MASK_OFF, 32'h2);
      @(posedge pclk);
      check({31'h0, irq}, 32'h1);
      apb(1'b1, INT_MASK_OFF, 32'h0);
      @(posedge pclk);
      check({31'h0, irq}, 32'h0);
      apb(1'b1, INT_STATUS_OFF, 32'h3);
      rchk(INT_STATUS_OFF, 32'h0);
      apb(1'b1, LINK_CTRL_SET_OFF, 32'h0020_0000);
      rchk(LINK_CTRL_SET_OFF, 32'h0020_0040);
   endtask

   task automatic t_not_root();
      phy_link_model_inst.send_node(6'h05, 1'b0);
      phy_link_model_inst.send_cycle_start(12'h123);
      @(posedge pclk);
      check({20'h0, cycle_offset}, 32'h123);
      apb(1'b1, LINK_CTRL_SET_OFF, 32'h0010_0000);
      wait_emit(1300);
      check({31'h0, cycle_start_emit}, 32'h0);
      apb(1'b1, LINK_CTRL_CLR_OFF, 32'h0010_0000);
   endtask

   task automatic t_receive();
      for (int e = 1; e >= 0; e--) begin
         apb(1'b1, (e == 1) ? LINK_CTRL_SET_OFF : LINK_CTRL_CLR_OFF, 32'h600);
         for (int i = 0; i < 8; i++) begin
            are <= i[0];
            phy_link_model_inst.set_rx(i[1], i[2]);
            @(posedge pclk);
            check({31'h0, phy_packet_accept}, {31'h0, i[0] & i[1] & e[0]});
            check({31'h0, self_id_accept}, {31'h0, i[2] & e[0]});
         end
      end
   endtask

   task automatic t_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rchk(LINK_CTRL_SET_OFF, 32'h0000_0000);
   endtask

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_defaults();
      t_sync_lock();
      t_node();
      t_internal();
      t_external();
      t_overlong();
      t_not_root();
      t_receive();
      t_reset();
      summarize();
   end

   initial begin
      repeat (30000) @(posedge pclk);
      err_count++;
      summarize();
   end
endmodule // test_link_control_cycle_timer
